//--- tb/crs_cpu.sv
// Execution and ALU side model driving the core ports
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_cpu (
	input  wire        clock_i,
	output reg         core_wr_en_o,
	output reg  [4:0]  core_wr_sel_o,
	output reg  [1:0]  core_wr_size_o,
	output reg  [1:0]  core_wr_part_o,
	output reg  [31:0] core_wr_data_o,
	output reg  [4:0]  core_rd_sel_o,
	output reg  [1:0]  core_rd_size_o,
	output reg  [1:0]  core_rd_part_o,
	output reg         pc_load_o,
	output reg  [31:0] pc_next_o,
	output reg         sp_wr_o,
	output reg  [31:0] sp_wr_data_o,
	output reg         alu_flag_we_o,
	output reg         alu_carry_o,
	output reg  [31:0] alu_result_o,
	output reg         fint_enter_o,
	output reg         fint_return_o,
	output reg  [3:0]  dma_reload_o
);
initial begin
	{core_wr_en_o, core_wr_sel_o, core_wr_size_o, core_wr_part_o, core_wr_data_o} = 0;
	{core_rd_sel_o, core_rd_size_o, core_rd_part_o, pc_load_o, pc_next_o, sp_wr_o} = 0;
	{sp_wr_data_o, alu_flag_we_o, alu_carry_o, alu_result_o} = 0;
	{fint_enter_o, fint_return_o, dma_reload_o} = 0;
end
task wr(input [4:0] s, input [1:0] z, input [1:0] p, input [31:0] d);
	begin
		@(posedge clock_i);
		{core_wr_en_o, core_wr_sel_o, core_wr_size_o, core_wr_part_o} <= {1'b1, s, z, p};
		core_wr_data_o <= (s == `CRS_IDX_FLG) ? d & ~(32'h1 << `CRS_FLG_D) : d;
		@(posedge clock_i);
		core_wr_en_o <= 1'b0;
		core_wr_data_o <= ~d;
		@(negedge clock_i);
	end
endtask
task rd(input [4:0] s, input [1:0] z, input [1:0] p);
	begin
		@(posedge clock_i);
		{core_rd_sel_o, core_rd_size_o, core_rd_part_o} <= {s, z, p};
		@(posedge clock_i);
		@(negedge clock_i);
	end
endtask
// Kinds: 1 pc, 2 sp, 3 alu, 4 enter, 5 return, 6 enter then return, 8+ch reload
task op(input [3:0] k, input [31:0] d, input c);
	begin
		@(posedge clock_i);
		{pc_next_o, alu_result_o, alu_carry_o} <= {d, d, c};
		sp_wr_data_o <= d & 32'hFFFF_FFFC;
		{pc_load_o, sp_wr_o, alu_flag_we_o} <= {k == 4'h1, k == 4'h2, k == 4'h3};
		{fint_enter_o, fint_return_o} <= {k == 4'h4 || k == 4'h6, k == 4'h5};
		dma_reload_o <= (k >= 4'h8) ? 4'h1 << (k - 4'h8) : 4'h0;
		@(posedge clock_i);
		{pc_load_o, sp_wr_o, alu_flag_we_o, fint_enter_o, dma_reload_o} <= 8'h00;
		fint_return_o <= (k == 4'h6);
		{pc_next_o, alu_result_o, sp_wr_data_o} <= ~{d, d, d};
		if (k == 4'h6) begin
			@(posedge clock_i);
			fint_return_o <= 1'b0;
		end
		@(negedge clock_i);
	end
endtask
endmodule // crs_cpu

//--- tb/crs_regset_properties.sv
// Concurrent checks on the register set top-level ports
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_regset_properties (
	input wire         clock_i,
	input wire         sys_rst_i,
	input wire         s_axi_awready_o,
	input wire         core_wr_en_i,
	input wire [4:0]   core_wr_sel_i,
	input wire [1:0]   core_wr_size_i,
	input wire [1:0]   core_wr_part_i,
	input wire [31:0]  core_wr_data_i,
	input wire         pc_load_i,
	input wire [31:0]  pc_next_i,
	input wire         sp_wr_i,
	input wire [31:0]  sp_wr_data_i,
	input wire         alu_flag_we_i,
	input wire         alu_carry_i,
	input wire [31:0]  alu_result_i,
	input wire         fint_enter_i,
	input wire         fint_return_i,
	input wire [127:0] addr_regs_o,
	input wire [31:0]  next_instr_pointer_o,
	input wire [31:0]  stack_ptr_o,
	input wire [31:0]  cpu_status_word_o
);
// --------------------
// Helpers and assertions
// --------------------
default clocking cb @(posedge clock_i); endclocking
default disable iff (sys_rst_i);
wire fint_any = fint_enter_i | fint_return_i;
wire quiet    = !core_wr_en_i && s_axi_awready_o && !fint_any;
wire a0_wr    = core_wr_en_i && core_wr_sel_i == `CRS_IDX_AR0 && s_axi_awready_o;
carry_flag_a: assert property (alu_flag_we_i && !fint_any |=> cpu_status_word_o[`CRS_FLG_C] == $past(alu_carry_i))
	else $error("carry flag wrong");
zero_flag_a: assert property (alu_flag_we_i && !fint_any |=> cpu_status_word_o[`CRS_FLG_Z] == ($past(alu_result_i) == 32'h0))
	else $error("zero flag wrong");
sign_flag_a: assert property (alu_flag_we_i && !fint_any |=> cpu_status_word_o[`CRS_FLG_S] == $past(alu_result_i[31]))
	else $error("sign flag wrong");
fast_restore_a: assert property (fint_enter_i ##1 (fint_return_i && !fint_enter_i) |=> cpu_status_word_o == $past(cpu_status_word_o, 2) && next_instr_pointer_o == $past(next_instr_pointer_o, 2))
	else $error("fast return did not restore");
pc_load_a: assert property (pc_load_i && !fint_any |=> next_instr_pointer_o == $past(pc_next_i))
	else $error("program counter load wrong");
stack_pick_a: assert property (sp_wr_i && quiet |=> stack_ptr_o == $past(sp_wr_data_i))
	else $error("selected stack pointer wrong");
addr_word_a: assert property (a0_wr && core_wr_size_i == `CRS_SZ_WORD |=> addr_regs_o[31:0] == $past(core_wr_data_i))
	else $error("address register word write wrong");
addr_half_a: assert property (a0_wr && core_wr_size_i == `CRS_SZ_HALF && core_wr_part_i[0] |=> addr_regs_o[31:16] == $past(core_wr_data_i[15:0]) && addr_regs_o[15:0] == $past(addr_regs_o[15:0]))
	else $error("address register half write wrong");
endmodule // crs_regset_properties

//--- tb/tb_top.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ps
`include "crs_consts.vh"
`define CHK(n, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin \
	errors = errors + 1; $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
reg          clock_i = 1'b0, sys_rst_i = 1'b1;
reg  [11:0]  s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
reg  [31:0]  s_axi_wdata_i = 32'h0, rd_d;
reg  [3:0]   s_axi_wstrb_i = 4'hF;
reg  [1:0]   rd_r;
reg          s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
reg          s_axi_arvalid_i = 0, s_axi_rready_i = 0;
wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
wire [1:0]   s_axi_bresp_o, s_axi_rresp_o, core_wr_size_i, core_wr_part_i;
wire [1:0]   core_rd_size_i, core_rd_part_i;
wire [31:0]  s_axi_rdata_o, core_rd_data_o, core_wr_data_i, pc_next_i, sp_wr_data_i;
wire [31:0]  alu_result_i, static_base_o, frame_base_o, next_instr_pointer_o;
wire [31:0]  vector_table_base_o, stack_ptr_o, cpu_status_word_o;
wire [4:0]   core_wr_sel_i, core_rd_sel_i;
wire         core_wr_en_i, pc_load_i, sp_wr_i, alu_flag_we_i, alu_carry_i;
wire         fint_enter_i, fint_return_i;
wire [3:0]   dma_reload_i;
wire [127:0] addr_regs_o, dma_mode_o, dma_src_addr_o, dma_dst_addr_o;
wire [95:0]  dma_xfer_count_o;
integer      errors = 0, check_count = 0;
always #4 clock_i = ~clock_i;
crs_regset crs_regset_inst (.*);
crs_cpu crs_cpu_inst (.clock_i, .core_wr_en_o(core_wr_en_i), .core_wr_sel_o(core_wr_sel_i),
	.core_wr_size_o(core_wr_size_i), .core_wr_part_o(core_wr_part_i),
	.core_wr_data_o(core_wr_data_i), .core_rd_sel_o(core_rd_sel_i),
	.core_rd_size_o(core_rd_size_i), .core_rd_part_o(core_rd_part_i),
	.pc_load_o(pc_load_i), .pc_next_o(pc_next_i), .sp_wr_o(sp_wr_i),
	.sp_wr_data_o(sp_wr_data_i), .alu_flag_we_o(alu_flag_we_i), .alu_carry_o(alu_carry_i),
	.alu_result_o(alu_result_i), .fint_enter_o(fint_enter_i), .fint_return_o(fint_return_i),
	.dma_reload_o(dma_reload_i));
// --------------------
// Bus tasks
// --------------------
function [11:0] ga(input [4:0] i);
	ga = {5'h00, i, 2'b00};
endfunction
task end_sim;
	begin
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
endtask
task axi_wr(input [11:0] a, input [31:0] d, output [1:0] r);
	integer n;
	reg aw, w, b;
	begin
		{aw, w, b} = 3'b000;
		@(posedge clock_i);
		{s_axi_awaddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i} <= {a, d, 2'b11};
		for (n = 0; n < 40 && !b; n = n + 1) begin
			@(posedge clock_i);
			if (s_axi_bready_i && s_axi_bvalid_o) begin
				{b, r} = {1'b1, s_axi_bresp_o};
				s_axi_bready_i <= 1'b0;
			end
			if (!aw && s_axi_awready_o) begin aw = 1'b1; s_axi_awvalid_i <= 1'b0; end
			if (!w && s_axi_wready_o) begin w = 1'b1; s_axi_wvalid_i <= 1'b0; end
			if (aw && w && !b) s_axi_bready_i <= 1'b1;
		end
		if (!b) begin errors = errors + 1; end_sim; end
	end
endtask
task rchk(input [11:0] a, input [31:0] e, input [1:0] er);
	integer n;
	reg ar, b;
	begin
		{ar, b} = 2'b00;
		@(posedge clock_i);
		{s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'b11};
		for (n = 0; n < 40 && !b; n = n + 1) begin
			@(posedge clock_i);
			if (ar && s_axi_rvalid_o) begin
				{b, rd_d, rd_r} = {1'b1, s_axi_rdata_o, s_axi_rresp_o};
				s_axi_rready_i <= 1'b0;
			end
			if (!ar && s_axi_arready_o) begin ar = 1'b1; s_axi_arvalid_i <= 1'b0; end
		end
		if (!b) begin errors = errors + 1; end_sim; end
		`CHK("read data", e, rd_d)
		`CHK("read resp", er, rd_r)
	end
endtask
// --------------------
// Scenarios
// --------------------
task t_map;
	begin
		rchk(ga(`CRS_IDX_FLG), 32'h0, `CRS_RESP_OKAY);
		axi_wr(ga(`CRS_IDX_SB), 32'h0001_2340, rd_r);
		s_axi_wstrb_i <= 4'hC;
		axi_wr(ga(`CRS_IDX_SB), 32'hAABB_CCDD, rd_r);
		s_axi_wstrb_i <= 4'hF;
		axi_wr(ga(`CRS_IDX_FB), 32'h0002_5670, rd_r);
		axi_wr(ga(`CRS_IDX_VECTOR_TABLE_BASE), 32'h0003_8000, rd_r);
		`CHK("static base", 32'hAABB_2340, static_base_o)
		`CHK("frame base", 32'h0002_5670, frame_base_o)
		`CHK("vector base", 32'h0003_8000, vector_table_base_o)
		rchk(12'h09C, 32'h0, `CRS_RESP_SLVERR);
		axi_wr(12'h0FC, 32'hFFFF_FFFF, rd_r);
		`CHK("unmapped write resp", `CRS_RESP_SLVERR, rd_r)
	end
endtask
task t_dma;
	integer k;
	reg [31:0] e;
	begin
		for (k = 0; k < 7; k = k + 1) begin
			axi_wr(12'h0C0 + {k[2:0], 2'b00}, 32'hFEDC_BA90 + k, rd_r);
			e = 32'hFEDC_BA90 + k;
			if (k == 1 || k == 2) e = e & `CRS_CNT_MASK;
			rchk(12'h0C0 + {k[2:0], 2'b00}, e, `CRS_RESP_OKAY);
		end
		`CHK("mode out", 32'hFEDC_BA90, dma_mode_o[95:64])
		`CHK("count out", 24'hDC_BA91, dma_xfer_count_o[71:48])
		`CHK("src out", 32'hFEDC_BA93, dma_src_addr_o[95:64])
		`CHK("dst out", 32'hFEDC_BA95, dma_dst_addr_o[95:64])
		crs_cpu_inst.op(4'hA, 32'h0, 1'b0);
		`CHK("count reload", 24'hDC_BA92, dma_xfer_count_o[71:48])
		`CHK("src reload", 32'hFEDC_BA94, dma_src_addr_o[95:64])
		`CHK("dst reload", 32'hFEDC_BA96, dma_dst_addr_o[95:64])
		`CHK("other channel", 24'h0, dma_xfer_count_o[23:0])
	end
endtask
task t_lanes;
	begin
		crs_cpu_inst.wr(`CRS_IDX_DP0, `CRS_SZ_WORD, 2'h0, 32'h1122_3344);
		crs_cpu_inst.wr(`CRS_IDX_DP0, `CRS_SZ_BYTE, 2'h3, 32'h0000_00AB);
		rchk(ga(`CRS_IDX_DP0), 32'hAB22_3344, `CRS_RESP_OKAY);
		crs_cpu_inst.wr(`CRS_IDX_DP0, `CRS_SZ_HALF, 2'h1, 32'h0000_5566);
		rchk(ga(`CRS_IDX_DP0), 32'h5566_3344, `CRS_RESP_OKAY);
		crs_cpu_inst.rd(`CRS_IDX_DP0, `CRS_SZ_BYTE, 2'h1);
		`CHK("byte read", 32'h0000_0033, core_rd_data_o)
		crs_cpu_inst.wr(5'h02, `CRS_SZ_WORD, 2'h0, 32'h7777_8888);
		crs_cpu_inst.wr(5'h02, `CRS_SZ_BYTE, 2'h1, 32'h0000_00FF);
		crs_cpu_inst.wr(5'h02, `CRS_SZ_HALF, 2'h1, 32'h0000_9999);
		rchk(ga(5'h02), 32'h9999_8888, `CRS_RESP_OKAY);
		crs_cpu_inst.rd(5'h02, `CRS_SZ_HALF, 2'h1);
		`CHK("half read", 32'h0000_9999, core_rd_data_o)
		crs_cpu_inst.wr(`CRS_IDX_AR0, `CRS_SZ_WORD, 2'h0, 32'hCAFE_0000);
		crs_cpu_inst.wr(`CRS_IDX_AR0, `CRS_SZ_HALF, 2'h1, 32'h0000_BEEF);
		crs_cpu_inst.rd(`CRS_IDX_AR0, `CRS_SZ_WORD, 2'h0);
		`CHK("addr reg out", 32'hBEEF_0000, addr_regs_o[31:0])
		`CHK("addr reg read", 32'hBEEF_0000, core_rd_data_o)
	end
endtask
task t_flags;
	begin
		crs_cpu_inst.op(4'h3, 32'h0, 1'b1);
		`CHK("zero flags", 4'h5, cpu_status_word_o[3:0])
		crs_cpu_inst.op(4'h3, 32'h8000_0000, 1'b0);
		`CHK("sign flags", 4'h8, cpu_status_word_o[3:0])
		crs_cpu_inst.op(4'h3, 32'h0000_0001, 1'b1);
		`CHK("carry flags", 4'h1, cpu_status_word_o[3:0])
	end
endtask
task t_stack;
	begin
		crs_cpu_inst.wr(`CRS_IDX_FLG, `CRS_SZ_WORD, 2'h0, 32'h0000_0082);
		`CHK("status", 32'h0000_0080, cpu_status_word_o)
		crs_cpu_inst.op(4'h2, 32'h0000_1003, 1'b0);
		`CHK("user sp", 32'h0000_1000, stack_ptr_o)
		crs_cpu_inst.wr(`CRS_IDX_FLG, `CRS_SZ_WORD, 2'h0, 32'h0);
		`CHK("intr sp", 32'h0, stack_ptr_o)
		crs_cpu_inst.op(4'h2, 32'h0000_2000, 1'b0);
		rchk(ga(`CRS_IDX_ISP), 32'h0000_2000, `CRS_RESP_OKAY);
		rchk(ga(`CRS_IDX_USP), 32'h0000_1000, `CRS_RESP_OKAY);
	end
endtask
task t_fint;
	begin
		axi_wr(ga(`CRS_IDX_VCT), 32'h0000_8000, rd_r);
		crs_cpu_inst.op(4'h1, 32'h0000_0400, 1'b0);
		`CHK("pc", 32'h0000_0400, next_instr_pointer_o)
		crs_cpu_inst.wr(`CRS_IDX_FLG, `CRS_SZ_WORD, 2'h0, 32'h0000_0085);
		crs_cpu_inst.op(4'h4, 32'h0, 1'b0);
		`CHK("fast target", 32'h0000_8000, next_instr_pointer_o)
		rchk(ga(`CRS_IDX_SVF), 32'h0000_0085, `CRS_RESP_OKAY);
		rchk(ga(`CRS_IDX_SVP), 32'h0000_0400, `CRS_RESP_OKAY);
		crs_cpu_inst.wr(`CRS_IDX_FLG, `CRS_SZ_WORD, 2'h0, 32'h0);
		crs_cpu_inst.op(4'h1, 32'h0000_8010, 1'b0);
		crs_cpu_inst.op(4'h5, 32'h0, 1'b0);
		`CHK("restored status", 32'h0000_0085, cpu_status_word_o)
		`CHK("restored pc", 32'h0000_0400, next_instr_pointer_o)
		crs_cpu_inst.op(4'h6, 32'h0, 1'b0);
		`CHK("quick return pc", 32'h0000_0400, next_instr_pointer_o)
	end
endtask
initial begin
	repeat (5) @(posedge clock_i);
	sys_rst_i <= 1'b0;
	t_map;
	t_dma;
	t_lanes;
	t_flags;
	t_stack;
	t_fint;
	end_sim;
end
endmodule // tb_top
bind crs_regset crs_regset_properties crs_regset_properties_inst (.*);

//--- verilog/crs_axil_slave.v
// AXI4-Lite slave front end: handshakes, write/read strobes
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_axil_slave #(
	parameter ADDR_W = 12
) (
	input  wire              clock_i,
	input  wire              sys_rst_i,
	input  wire [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire              s_axi_awvalid_i,
	output wire              s_axi_awready_o,
	input  wire [31:0]       s_axi_wdata_i,
	input  wire [3:0]        s_axi_wstrb_i,
	input  wire              s_axi_wvalid_i,
	output wire              s_axi_wready_o,
	output wire [1:0]        s_axi_bresp_o,
	output wire              s_axi_bvalid_o,
	input  wire              s_axi_bready_i,
	input  wire [ADDR_W-1:0] s_axi_araddr_i,
	input  wire              s_axi_arvalid_i,
	output wire              s_axi_arready_o,
	output wire [31:0]       s_axi_rdata_o,
	output wire [1:0]        s_axi_rresp_o,
	output wire              s_axi_rvalid_o,
	input  wire              s_axi_rready_i,
	output wire              wr_o,
	output wire [ADDR_W-1:0] wr_addr_o,
	output wire [31:0]       wr_data_o,
	output wire [3:0]        wr_strb_o,
	input  wire              wr_err_i,
	output wire [ADDR_W-1:0] rd_addr_o,
	input  wire [31:0]       rd_data_i,
	input  wire              rd_err_i
);
	reg              awready_r;
	reg              wready_r;
	reg              bvalid_r;
	reg [1:0]        bresp_r;
	reg              arready_r;
	reg              rvalid_r;
	reg [31:0]       rdata_r;
	reg [1:0]        rresp_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [31:0]       wdata_r;
	reg [3:0]        wstrb_r;

	// Both halves held, previous response gone
	assign wr_o      = ~awready_r & ~wready_r & ~bvalid_r;
	assign wr_addr_o = awaddr_r;
	assign wr_data_o = wdata_r;
	assign wr_strb_o = wstrb_r;
	assign rd_addr_o = s_axi_araddr_i;

	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o  = wready_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CRS_RESP_OKAY;
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= `CRS_RST_WORD;
			rresp_r   <= `CRS_RESP_OKAY;
			awaddr_r  <= {ADDR_W{1'b0}};
			wdata_r   <= `CRS_RST_WORD;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && awready_r) begin
				awaddr_r  <= s_axi_awaddr_i;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid_i && wready_r) begin
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
				wready_r <= 1'b0;
			end
			if (wr_o) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_err_i ? `CRS_RESP_SLVERR : `CRS_RESP_OKAY;
			end
			if (bvalid_r && s_axi_bready_i) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
			if (s_axi_arvalid_i && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_data_i;
				rresp_r   <= rd_err_i ? `CRS_RESP_SLVERR : `CRS_RESP_OKAY;
			end
			if (rvalid_r && s_axi_rready_i) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end
endmodule // crs_axil_slave

//--- verilog/crs_consts.vh
// Constants for the CPU register set: map, fields, reset values
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
// --------------------
// General register indices (byte addr = 4 * index)
// --------------------
`define CRS_IDX_DP0      5'h00
`define CRS_IDX_DP1      5'h01
`define CRS_IDX_AR0      5'h04
`define CRS_IDX_SB       5'h08
`define CRS_IDX_FB       5'h09
`define CRS_IDX_PC       5'h0A
`define CRS_IDX_VECTOR_TABLE_BASE     5'h0B
`define CRS_IDX_USP      5'h0C
`define CRS_IDX_ISP      5'h0D
`define CRS_IDX_FLG      5'h0E
`define CRS_IDX_SVF      5'h0F
`define CRS_IDX_SVP      5'h10
`define CRS_IDX_VCT      5'h11
`define CRS_NUM_GPR      18
// --------------------
// DMA block: addr[11:7]=1, channel addr[6:5], kind addr[4:2]
// --------------------
`define CRS_PAGE_GPR     5'h00
`define CRS_PAGE_DMA     5'h01
`define CRS_DMA_KINDS    5'h07
`define CRS_NUM_DMA      28
`define CRS_DK_MODE      3'h0
`define CRS_DK_CNT       3'h1
`define CRS_DK_CNTRL     3'h2
`define CRS_DK_SRC       3'h3
`define CRS_DK_SRCRL     3'h4
`define CRS_DK_DST       3'h5
`define CRS_DK_DSTRL     3'h6
// --------------------
// Status word fields
// --------------------
`define CRS_FLG_C        0
`define CRS_FLG_D        1
`define CRS_FLG_Z        2
`define CRS_FLG_S        3
`define CRS_FLG_U        7
// --------------------
// Reset values, masks, access sizes, responses
// --------------------
`define CRS_RST_WORD     32'h0000_0000
`define CRS_CNT_MASK     32'h00FF_FFFF
`define CRS_SZ_BYTE      2'h0
`define CRS_SZ_HALF      2'h1
`define CRS_SZ_WORD      2'h2
`define CRS_RESP_OKAY    2'h0
`define CRS_RESP_SLVERR  2'h2
`endif

//--- verilog/crs_lane_merge.v
// Byte/half/word merge and extract for sub-register access
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_lane_merge (
	input  wire [31:0] old_i,
	input  wire [31:0] data_i,
	input  wire [1:0]  size_i,
	input  wire [1:0]  part_i,
	output reg  [31:0] merged_o,
	output reg  [31:0] field_o
);
	// Lane 3 upper, 2 mid-upper, 1 mid-lower, 0 lower
	always @* begin
		merged_o = old_i;
		field_o  = old_i;
		case (size_i)
			`CRS_SZ_BYTE: begin
				merged_o[{part_i, 3'b000} +: 8] = data_i[7:0];
				field_o = {24'h000000, old_i[{part_i, 3'b000} +: 8]};
			end
			`CRS_SZ_HALF: begin
				merged_o[{part_i[0], 4'h0} +: 16] = data_i[15:0];
				field_o = {16'h0000, old_i[{part_i[0], 4'h0} +: 16]};
			end
			default: begin
				merged_o = data_i;
			end
		endcase
	end
endmodule // crs_lane_merge

//--- verilog/crs_regset.v
// CPU programmer-visible register set with DMA channel registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_regset #(
	parameter ADDR_W = 12,
	parameter NUM_CH = 4
) (
	input  wire                clock_i,
	input  wire                sys_rst_i,
	// AXI4-Lite register port
	input  wire [ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire                s_axi_awvalid_i,
	output wire                s_axi_awready_o,
	input  wire [31:0]         s_axi_wdata_i,
	input  wire [3:0]          s_axi_wstrb_i,
	input  wire                s_axi_wvalid_i,
	output wire                s_axi_wready_o,
	output wire [1:0]          s_axi_bresp_o,
	output wire                s_axi_bvalid_o,
	input  wire                s_axi_bready_i,
	input  wire [ADDR_W-1:0]   s_axi_araddr_i,
	input  wire                s_axi_arvalid_i,
	output wire                s_axi_arready_o,
	output wire [31:0]         s_axi_rdata_o,
	output wire [1:0]          s_axi_rresp_o,
	output wire                s_axi_rvalid_o,
	input  wire                s_axi_rready_i,
	// Execution-side register port
	input  wire                core_wr_en_i,
	input  wire [4:0]          core_wr_sel_i,
	input  wire [1:0]          core_wr_size_i,
	input  wire [1:0]          core_wr_part_i,
	input  wire [31:0]         core_wr_data_i,
	input  wire [4:0]          core_rd_sel_i,
	input  wire [1:0]          core_rd_size_i,
	input  wire [1:0]          core_rd_part_i,
	output reg  [31:0]         core_rd_data_o,
	// Program counter, stack and ALU flags
	input  wire                pc_load_i,
	input  wire [31:0]         pc_next_i,
	input  wire                sp_wr_i,
	input  wire [31:0]         sp_wr_data_i,
	input  wire                alu_flag_we_i,
	input  wire                alu_carry_i,
	input  wire [31:0]         alu_result_i,
	// Fast interrupt sequencing
	input  wire                fint_enter_i,
	input  wire                fint_return_i,
	// DMA reload strobes, one per channel
	input  wire [NUM_CH-1:0]   dma_reload_i,
	// Register contents to the core and DMA engine
	output wire [127:0]        addr_regs_o,
	output wire [31:0]         static_base_o,
	output wire [31:0]         frame_base_o,
	output wire [31:0]         next_instr_pointer_o,
	output wire [31:0]         vector_table_base_o,
	output wire [31:0]         stack_ptr_o,
	output wire [31:0]         cpu_status_word_o,
	output wire [NUM_CH*32-1:0] dma_mode_o,
	output wire [NUM_CH*24-1:0] dma_xfer_count_o,
	output wire [NUM_CH*32-1:0] dma_src_addr_o,
	output wire [NUM_CH*32-1:0] dma_dst_addr_o
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg  [31:0]       gpr_r [0:`CRS_NUM_GPR-1];
	reg  [31:0]       dma_r [0:`CRS_NUM_DMA-1];
	integer           i;
	integer           c;

	wire              bus_wr;
	wire [ADDR_W-1:0] bus_waddr;
	wire [31:0]       bus_wdata;
	wire [3:0]        bus_wstrb;
	wire [ADDR_W-1:0] bus_raddr;
	reg  [31:0]       bus_rdata;
	reg               bus_rerr;
	reg               bus_werr;
	wire [31:0]       core_merged;
	wire [31:0]       core_field;

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	crs_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.clock_i         (clock_i),
		.sys_rst_i       (sys_rst_i),
		.s_axi_awaddr_i  (s_axi_awaddr_i),
		.s_axi_awvalid_i (s_axi_awvalid_i),
		.s_axi_awready_o (s_axi_awready_o),
		.s_axi_wdata_i   (s_axi_wdata_i),
		.s_axi_wstrb_i   (s_axi_wstrb_i),
		.s_axi_wvalid_i  (s_axi_wvalid_i),
		.s_axi_wready_o  (s_axi_wready_o),
		.s_axi_bresp_o   (s_axi_bresp_o),
		.s_axi_bvalid_o  (s_axi_bvalid_o),
		.s_axi_bready_i  (s_axi_bready_i),
		.s_axi_araddr_i  (s_axi_araddr_i),
		.s_axi_arvalid_i (s_axi_arvalid_i),
		.s_axi_arready_o (s_axi_arready_o),
		.s_axi_rdata_o   (s_axi_rdata_o),
		.s_axi_rresp_o   (s_axi_rresp_o),
		.s_axi_rvalid_o  (s_axi_rvalid_o),
		.s_axi_rready_i  (s_axi_rready_i),
		.wr_o            (bus_wr),
		.wr_addr_o       (bus_waddr),
		.wr_data_o       (bus_wdata),
		.wr_strb_o       (bus_wstrb),
		.wr_err_i        (bus_werr),
		.rd_addr_o       (bus_raddr),
		.rd_data_i       (bus_rdata),
		.rd_err_i        (bus_rerr)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire [4:0] w_page  = bus_waddr[11:7];
	wire [4:0] w_idx   = bus_waddr[6:2];
	wire [4:0] w_didx  = {3'b000, bus_waddr[6:5]} * `CRS_DMA_KINDS
	                   + {2'b00, bus_waddr[4:2]};
	wire [4:0] r_page  = bus_raddr[11:7];
	wire [4:0] r_idx   = bus_raddr[6:2];
	wire [4:0] r_didx  = {3'b000, bus_raddr[6:5]} * `CRS_DMA_KINDS
	                   + {2'b00, bus_raddr[4:2]};
	wire       w_gpr   = (w_page == `CRS_PAGE_GPR) && (w_idx < `CRS_NUM_GPR);
	wire       w_dma   = (w_page == `CRS_PAGE_DMA) && (bus_waddr[4:2] != 3'h7);
	wire       r_gpr   = (r_page == `CRS_PAGE_GPR) && (r_idx < `CRS_NUM_GPR);
	wire       r_dma   = (r_page == `CRS_PAGE_DMA) && (bus_raddr[4:2] != 3'h7);
	wire       w_cnt   = (bus_waddr[4:2] == `CRS_DK_CNT)
	                   || (bus_waddr[4:2] == `CRS_DK_CNTRL);
	wire       r_cnt   = (bus_raddr[4:2] == `CRS_DK_CNT)
	                   || (bus_raddr[4:2] == `CRS_DK_CNTRL);

	// Old value of the addressed word, for byte strobes
	reg  [31:0] w_old;
	wire [31:0] w_smask = {{8{bus_wstrb[3]}}, {8{bus_wstrb[2]}},
	                       {8{bus_wstrb[1]}}, {8{bus_wstrb[0]}}};
	wire [31:0] w_new   = (bus_wdata & w_smask) | (w_old & ~w_smask);

	always @* begin
		w_old    = `CRS_RST_WORD;
		bus_werr = 1'b1;
		if (w_gpr) begin
			w_old    = gpr_r[w_idx];
			bus_werr = 1'b0;
		end else if (w_dma) begin
			w_old    = dma_r[w_didx];
			bus_werr = 1'b0;
		end
	end

	// 24-bit counts read their upper byte as zero
	always @* begin
		bus_rdata = `CRS_RST_WORD;
		bus_rerr  = 1'b1;
		if (r_gpr) begin
			bus_rdata = gpr_r[r_idx];
			bus_rerr  = 1'b0;
		end else if (r_dma) begin
			bus_rdata = r_cnt ? (dma_r[r_didx] & `CRS_CNT_MASK) : dma_r[r_didx];
			bus_rerr  = 1'b0;
		end
	end

	// ----------------------------------------
	// Sub-register access from the core
	// ----------------------------------------
	crs_lane_merge u_wr_lane (
		.old_i    (gpr_r[core_wr_sel_i]),
		.data_i   (core_wr_data_i),
		.size_i   (core_wr_size_i),
		.part_i   (core_wr_part_i),
		.merged_o (core_merged),
		.field_o  ()
	);

	crs_lane_merge u_rd_lane (
		.old_i    (gpr_r[core_rd_sel_i]),
		.data_i   (`CRS_RST_WORD),
		.size_i   (core_rd_size_i),
		.part_i   (core_rd_part_i),
		.merged_o (),
		.field_o  (core_field)
	);

	// Bytes exist only in the first two data registers, DP0 and DP1
	wire core_wr_ok = core_wr_en_i && (core_wr_sel_i < `CRS_NUM_GPR)
	                && ((core_wr_size_i != `CRS_SZ_BYTE)
	                || (core_wr_sel_i <= `CRS_IDX_DP1));
	wire core_rd_ok = (core_rd_sel_i < `CRS_NUM_GPR)
	                && ((core_rd_size_i != `CRS_SZ_BYTE)
	                || (core_rd_sel_i <= `CRS_IDX_DP1));

	wire       use_usp = gpr_r[`CRS_IDX_FLG][`CRS_FLG_U];
	wire [4:0] sp_idx  = use_usp ? `CRS_IDX_USP : `CRS_IDX_ISP;

	// ----------------------------------------
	// Register update, later statements win
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			for (i = 0; i < `CRS_NUM_GPR; i = i + 1) begin
				gpr_r[i] <= `CRS_RST_WORD;
			end
			for (i = 0; i < `CRS_NUM_DMA; i = i + 1) begin
				dma_r[i] <= `CRS_RST_WORD;
			end
			core_rd_data_o <= `CRS_RST_WORD;
		end else begin
			core_rd_data_o <= core_rd_ok ? core_field : `CRS_RST_WORD;
			if (bus_wr && w_gpr) begin
				gpr_r[w_idx] <= w_new;
			end
			if (bus_wr && w_dma) begin
				dma_r[w_didx] <= w_cnt ? (w_new & `CRS_CNT_MASK) : w_new;
			end
			// Reload working registers from their reload copies
			for (c = 0; c < NUM_CH; c = c + 1) begin
				if (dma_reload_i[c]) begin
					dma_r[c*7+1] <= dma_r[c*7+2] & `CRS_CNT_MASK;
					dma_r[c*7+3] <= dma_r[c*7+4];
					dma_r[c*7+5] <= dma_r[c*7+6];
				end
			end
			if (core_wr_ok) begin
				gpr_r[core_wr_sel_i] <= core_merged;
			end
			if (sp_wr_i) begin
				gpr_r[sp_idx] <= sp_wr_data_i;
			end
			if (pc_load_i) begin
				gpr_r[`CRS_IDX_PC] <= pc_next_i;
			end
			if (alu_flag_we_i) begin
				gpr_r[`CRS_IDX_FLG][`CRS_FLG_C] <= alu_carry_i;
				gpr_r[`CRS_IDX_FLG][`CRS_FLG_Z] <= (alu_result_i == 32'h0000_0000);
				gpr_r[`CRS_IDX_FLG][`CRS_FLG_S] <= alu_result_i[31];
			end
			if (fint_enter_i) begin
				gpr_r[`CRS_IDX_SVF] <= gpr_r[`CRS_IDX_FLG];
				gpr_r[`CRS_IDX_SVP] <= gpr_r[`CRS_IDX_PC];
				gpr_r[`CRS_IDX_PC]  <= gpr_r[`CRS_IDX_VCT];
			end else if (fint_return_i) begin
				gpr_r[`CRS_IDX_FLG] <= gpr_r[`CRS_IDX_SVF];
				gpr_r[`CRS_IDX_PC]  <= gpr_r[`CRS_IDX_SVP];
			end
		end
	end

	// ----------------------------------------
	// Register contents out
	// ----------------------------------------
	assign addr_regs_o = {gpr_r[`CRS_IDX_AR0+3], gpr_r[`CRS_IDX_AR0+2],
	                      gpr_r[`CRS_IDX_AR0+1], gpr_r[`CRS_IDX_AR0]};
	assign static_base_o        = gpr_r[`CRS_IDX_SB];
	assign frame_base_o         = gpr_r[`CRS_IDX_FB];
	assign next_instr_pointer_o = gpr_r[`CRS_IDX_PC];
	assign vector_table_base_o  = gpr_r[`CRS_IDX_VECTOR_TABLE_BASE];
	assign stack_ptr_o          = gpr_r[sp_idx];
	assign cpu_status_word_o    = gpr_r[`CRS_IDX_FLG];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
			assign dma_mode_o[g*32 +: 32]       = dma_r[g*7];
			assign dma_xfer_count_o[g*24 +: 24] = dma_r[g*7+1][23:0];
			assign dma_src_addr_o[g*32 +: 32]   = dma_r[g*7+3];
			assign dma_dst_addr_o[g*32 +: 32]   = dma_r[g*7+5];
		end
	endgenerate
endmodule // crs_regset
